//--- cifr_top.sv
// Flag, interrupt mask, word counter, FIFO window and clock gate registers
`timescale 1ns/1ps
`include "cifr_cfg.svh"

// Function
// [RULE1] Writing one clears matching sticky flag
// [RULE2] Software writes zeros to reserved clear bits
// [RULE3] Mask bit one lets flag reach irq
// [RULE4] Two irq lines, each with own mask
// [RULE5] Both masks reset to zero
// [RULE6] Counter loads length on data enable
// [RULE7] Fifteen bit count of words left
// [RULE8] Trailing partial word counts as whole
// [RULE9] Window writes push, reads pop
// [RULE10] Every window address reaches the FIFO
// [RULE11] Clock gate bit resets to zero
// [RULE12] Software enables clock before other accesses
// [RULE13] Writing zero stops interface clock
// [RULE14] Low flags stay set until cleared
// [RULE15] High flags follow live logic
// [RULE16] Irq high while flag and mask
module cifr_top
	import cifr_pkg::*;
#(
	parameter int LEN_W = `CIFR_LEN_W,
	parameter int WIN_WORDS = `CIFR_WIN_WORDS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Card interface state machines
	input wire logic [10:0] stickyEvt,
	input wire logic [10:0] liveFlags,
	input wire logic [LEN_W-1:0] transferLength,
	input wire logic dataEnableSet,
	input wire logic wordMoved,
	// Transmit FIFO push side
	output logic txPushValid,
	output logic [31:0] txPushData,
	input wire logic txPushReady,
	// Receive FIFO pop side
	input wire logic rxPopValid,
	input wire logic [31:0] rxPopData,
	output logic rxPopReady,
	// Interrupts and clock gate
	output logic irq0,
	output logic irq1,
	output logic cardIfClkEn
);

	localparam int CNT_W = LEN_W - 1;

	// Refuse sizes the rounding and window decode cannot serve
	if (LEN_W < 3 || WIN_WORDS != 16) begin : gBadParam
		$error("cifr_top: unsupported LEN_W or WIN_WORDS");
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// True for any word of the FIFO window
	function automatic logic isWindow(input logic [31:0] a);
		isWindow = (a >= `CIFR_WIN_LO_OFS) && (a <= `CIFR_WIN_HI_OFS);
	endfunction

	// True for any address that answers without an error, and also for unaligned addresses inside the FIFO window
	function automatic logic isMapped(input logic [31:0] a);
		isMapped = isWindow(a) || a == `CIFR_CLKGATE_OFS || a == `CIFR_FLAGS_OFS
			|| a == `CIFR_CLEAR_OFS || a == `CIFR_MASK0_OFS
			|| a == `CIFR_MASK1_OFS || a == `CIFR_WORDS_OFS;
	endfunction

	logic readyQ, readyD;
	logic errQ, errD;
	cifr_word_t prdataQ, prdataD;
	logic access, done, wr, winHit, canFinish, aligned;
	cifr_word_t readVal;

	cifr_sticky_t stickyQ, stickyD;
	cifr_flags_t flagsAll;
	cifr_flags_t mask0Q, mask0D;
	cifr_flags_t mask1Q, mask1D;
	logic [CNT_W-1:0] wordsLeftQ, wordsLeftD;
	logic [CNT_W-1:0] lenWords;
	logic [LEN_W:0] lenRound;
	logic clkEnQ, clkEnD;
	logic slotValidQ, slotValidD;
	cifr_word_t slotDataQ, slotDataD;
	logic irq0Q, irq0D, irq1Q, irq1D;
	logic clrHit;

	// Phases of the transfer; one wait state keeps read data in a flop
	assign access = psel && penable;
	assign done = access && readyQ;
	assign wr = done && pwrite;
	assign aligned = (paddr[1:0] == 2'h0);
	assign winHit = isWindow(paddr) && aligned; // [RULE10]
	assign clrHit = wr && paddr == `CIFR_CLEAR_OFS;

	// A window write waits for a free slot, a window read for data
	always_comb begin
		if (winHit && pwrite) begin
			canFinish = !slotValidQ;
		end else if (winHit) begin
			canFinish = rxPopValid;
		end else begin
			canFinish = 1'b1;
		end
	end

	// Pop in the cycle the read data is captured
	assign rxPopReady = access && !readyQ && !pwrite && winHit && rxPopValid; // [RULE9]

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer

	always_comb begin
		readVal = 32'h00000000;
		if (winHit) begin
			readVal = rxPopData; // [RULE9]
		end else begin
			case (paddr)
				`CIFR_CLKGATE_OFS: readVal = {31'h00000000, clkEnQ};
				`CIFR_FLAGS_OFS: readVal = {10'h000, flagsAll};
				`CIFR_MASK0_OFS: readVal = {10'h000, mask0Q};
				`CIFR_MASK1_OFS: readVal = {10'h000, mask1Q};
				`CIFR_WORDS_OFS: readVal = {{(32-CNT_W){1'b0}}, wordsLeftQ}; // [RULE7]
				default: readVal = 32'h00000000; // Clear register reads zero
			endcase
		end
	end

	// Bus answer state
	always_comb begin
		readyD = 1'b0;
		errD = 1'b0;
		prdataD = prdataQ;
		if (access && !readyQ && canFinish) begin
			readyD = 1'b1;
			errD = !(isMapped(paddr) && aligned);
			if (!pwrite) begin
				prdataD = errD ? 32'h00000000 : readVal;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			readyQ <= 1'b0;
			errQ <= 1'b0;
			prdataQ <= 32'h00000000;
		end else begin
			readyQ <= readyD;
			errQ <= errD;
			prdataQ <= prdataD;
		end
	end

	assign pready = readyQ;
	assign pslverr = readyQ && errQ;
	assign prdata = prdataQ;

	////////////////////////////////////////////////////////////////////////
	// Status flags and masks

	// Reserved clear bits are dropped by the part-select
	always_comb begin
		stickyD = stickyQ;
		if (clrHit) begin
			stickyD = stickyQ & ~pwdata[`CIFR_STICKY_MSB:0]; // [RULE1] [RULE2]
		end
		stickyD = stickyD | stickyEvt; // [RULE14] set beats a clear
	end

	assign flagsAll = {liveFlags, stickyQ}; // [RULE15]

	// Mask writes take effect at the completing edge only
	always_comb begin
		mask0D = mask0Q;
		mask1D = mask1Q;
		if (wr && paddr == `CIFR_MASK0_OFS) begin
			mask0D = pwdata[`CIFR_FLAG_MSB:0]; // [RULE3]
		end
		if (wr && paddr == `CIFR_MASK1_OFS) begin
			mask1D = pwdata[`CIFR_FLAG_MSB:0]; // [RULE3]
		end
	end

	// Registered irqs see the sticky flags and masks as they will stand next cycle, the live bits as they stand now
	always_comb begin
		irq0D = |({liveFlags, stickyD} & mask0D); // [RULE4] [RULE16]
		irq1D = |({liveFlags, stickyD} & mask1D); // [RULE4] [RULE16]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stickyQ <= `CIFR_STICKY_RST;
			mask0Q <= `CIFR_MASK_RST; // [RULE5]
			mask1Q <= `CIFR_MASK_RST; // [RULE5]
			irq0Q <= 1'b0;
			irq1Q <= 1'b0;
		end else begin
			stickyQ <= stickyD;
			mask0Q <= mask0D;
			mask1Q <= mask1D;
			irq0Q <= irq0D;
			irq1Q <= irq1D;
		end
	end

	// Live bits change between edges, so the level is kept from flops
	assign irq0 = irq0Q;
	assign irq1 = irq1Q;

	////////////////////////////////////////////////////////////////////////
	// Word counter

	// Round bytes up to words
	assign lenRound = {1'b0, transferLength} + (LEN_W+1)'(`CIFR_BYTES_PER_WORD - 1);
	assign lenWords = lenRound[LEN_W:2]; // [RULE8]

	// Load wins over a move in the same cycle
	always_comb begin
		wordsLeftD = wordsLeftQ;
		if (dataEnableSet) begin
			wordsLeftD = lenWords; // [RULE6]
		end else if (wordMoved && wordsLeftQ != '0) begin
			wordsLeftD = wordsLeftQ - CNT_W'(1); // [RULE7]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wordsLeftQ <= '0;
		end else begin
			wordsLeftQ <= wordsLeftD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// FIFO window write slot and clock gate

	// One holding word so the push data comes from a flop
	always_comb begin
		slotValidD = slotValidQ;
		slotDataD = slotDataQ;
		if (slotValidQ && txPushReady) begin
			slotValidD = 1'b0;
		end
		if (wr && winHit) begin
			slotValidD = 1'b1; // [RULE9]
			slotDataD = pwdata;
		end
	end

	// The gate cell sits outside; this flop only steers it
	always_comb begin
		clkEnD = clkEnQ;
		if (wr && paddr == `CIFR_CLKGATE_OFS) begin
			clkEnD = pwdata[`CIFR_CLKEN_BIT]; // [RULE13]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slotValidQ <= 1'b0;
			slotDataQ <= 32'h00000000;
			clkEnQ <= `CIFR_CLKEN_RST; // [RULE11]
		end else begin
			slotValidQ <= slotValidD;
			slotDataQ <= slotDataD;
			clkEnQ <= clkEnD;
		end
	end

	assign txPushValid = slotValidQ;
	assign txPushData = slotDataQ;
	assign cardIfClkEn = clkEnQ;

	////////////////////////////////////////////////////////////////////////
	// Checks

	AST_CLEAR_ONE: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
		clrHit && pwdata[0] && !stickyEvt[0] |=> !stickyQ[0])
		else $error("clear write left flag 0 set");

	AST_CLEAR_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
		clrHit && !pwdata[3] && stickyQ[3] |=> stickyQ[3])
		else $error("zero clear bit dropped flag 3");

	AST_STICKY_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [RULE14]
		stickyQ[5] && !(clrHit && pwdata[5]) |=> stickyQ[5])
		else $error("sticky flag 5 fell without clear");

	AST_LIVE_READ: assert property (@(posedge sys_clk) disable iff (rst) // [RULE15]
		access && !readyQ && !pwrite && paddr == `CIFR_FLAGS_OFS
		|=> pready && prdata[21:11] == $past(liveFlags))
		else $error("live flags not read back");

	AST_MASK_RESET: assert property (@(posedge sys_clk) // [RULE5]
		$past(rst) |-> mask0Q == '0 && mask1Q == '0 && !irq0 && !irq1)
		else $error("mask not zero after reset");

	AST_IRQ0_RAISE: assert property (@(posedge sys_clk) disable iff (rst) // [RULE4]
		stickyEvt[2] && mask0Q[2] && !(wr && paddr == `CIFR_MASK0_OFS) |=> irq0)
		else $error("irq0 missed enabled flag");

	AST_IRQ1_MASKED: assert property (@(posedge sys_clk) disable iff (rst) // [RULE16]
		irq1 == |({$past(liveFlags), stickyQ} & mask1Q))
		else $error("irq1 differs from masked flags");

	AST_CNT_LOAD: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
		dataEnableSet
		|=> wordsLeftQ == CNT_W'((32'($past(transferLength)) + 32'h3) >> 2))
		else $error("counter not loaded with rounded length");

	AST_CNT_DEC: assert property (@(posedge sys_clk) disable iff (rst) // [RULE7]
		wordMoved && !dataEnableSet && wordsLeftQ != '0
		|=> wordsLeftQ == $past(wordsLeftQ) - CNT_W'(1))
		else $error("counter did not step down");

	AST_CLKEN_WR: assert property (@(posedge sys_clk) disable iff (rst) // [RULE13]
		wr && paddr == `CIFR_CLKGATE_OFS |=> cardIfClkEn == $past(pwdata[0]))
		else $error("clock gate not written");

	AST_WIN_PUSH: assert property (@(posedge sys_clk) disable iff (rst) // [RULE10]
		wr && winHit |=> txPushValid && txPushData == $past(pwdata))
		else $error("window write not pushed");

	AST_RX_POP: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
		rxPopReady |=> pready && prdata == $past(rxPopData))
		else $error("window read data lost");

endmodule

//--- cifr_cfg.svh
// Register map, field positions, reset values and counts of the card interface flag block
`ifndef CIFR_CFG_SVH
`define CIFR_CFG_SVH
// Byte addresses on the register bus
`define CIFR_CLKGATE_OFS 32'h8000502c
`define CIFR_FLAGS_OFS 32'h80100034
`define CIFR_CLEAR_OFS 32'h80100038
`define CIFR_MASK0_OFS 32'h8010003c
`define CIFR_MASK1_OFS 32'h80100040
`define CIFR_WORDS_OFS 32'h80100048
`define CIFR_WIN_LO_OFS 32'h80100080
`define CIFR_WIN_HI_OFS 32'h801000bc
// Field positions
`define CIFR_STICKY_MSB 10
`define CIFR_LIVE_LSB 11
`define CIFR_FLAG_MSB 21
`define CIFR_CLKEN_BIT 0
// Reset values
`define CIFR_MASK_RST 22'h000000
`define CIFR_STICKY_RST 11'h000
`define CIFR_CLKEN_RST 1'b0
// Counts
`define CIFR_WIN_WORDS 16
`define CIFR_LEN_W 16
`define CIFR_BYTES_PER_WORD 4
`endif

//--- cifr_pkg.sv
// Types shared by the card interface flag block
package cifr_pkg;
	typedef logic [21:0] cifr_flags_t;
	typedef logic [10:0] cifr_sticky_t;
	typedef logic [10:0] cifr_live_t;
	typedef logic [31:0] cifr_word_t;
endpackage

//--- cifr_card_model.sv
// Behavioural card-side model: transmit sink and receive source
`timescale 1ns/1ps
module cifr_card_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Random stall from the bench
	input wire logic go,
	// Transmit side
	input wire logic txPushValid,
	output logic txPushReady,
	// Receive side
	output logic rxPopValid,
	output logic [31:0] rxPopData,
	input wire logic rxPopReady
);
	logic vQ;
	logic [31:0] cntQ;
	// Sink stalls whenever go is low
	assign txPushReady = go;
	assign rxPopValid = vQ;
	// Stale data is inverted so a pop outside valid cannot match
	assign rxPopData = vQ ? cntQ : ~cntQ;
	// Word held until popped, then the next number follows
	always @(posedge sys_clk) begin
		if (rst) begin
			vQ <= 1'b0;
			cntQ <= 32'h5a000000;
		end else if (vQ && rxPopReady) begin
			vQ <= 1'b0;
			cntQ <= cntQ + 32'h1;
		end else if (!vQ) begin
			vQ <= go;
		end
	end
endmodule

//--- cifr_top_tb.sv
// Self-checking bench of the card interface flag block
`timescale 1ns/1ps
`include "cifr_cfg.svh"
module cifr_top_tb import cifr_pkg::*; ;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic dataEnableSet = 0, wordMoved = 0, go = 0, rerr;
	logic [31:0] paddr = 0, pwdata = 0, rdat, d;
	logic [10:0] stickyEvt = 0, liveFlags = 0, st = 0, v;
	logic [15:0] transferLength = 0;
	logic [21:0] m0 = 0, m1 = 0;
	wire logic [31:0] prdata, txPushData, rxPopData;
	wire logic pready, pslverr, txPushValid, txPushReady, rxPopValid, rxPopReady;
	wire logic irq0, irq1, cardIfClkEn;
	int miscompares = 0, checks_done = 0, seed = 46, w;
	int lens[6] = '{0, 1, 4, 5, 7, 65535};
	logic [31:0] radr[4] = '{`CIFR_MASK0_OFS, `CIFR_MASK1_OFS, `CIFR_WORDS_OFS, `CIFR_FLAGS_OFS};
	cifr_word_t txq[$];
	always #12.5 sys_clk = ~sys_clk;
	cifr_top cifr_top_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stickyEvt(stickyEvt), .liveFlags(liveFlags),
		.transferLength(transferLength), .dataEnableSet(dataEnableSet), .wordMoved(wordMoved),
		.txPushValid(txPushValid), .txPushData(txPushData), .txPushReady(txPushReady),
		.rxPopValid(rxPopValid), .rxPopData(rxPopData), .rxPopReady(rxPopReady),
		.irq0(irq0), .irq1(irq1), .cardIfClkEn(cardIfClkEn));
	cifr_card_model cifr_card_model_i (.sys_clk(sys_clk), .rst(rst), .go(go),
		.txPushValid(txPushValid), .txPushReady(txPushReady), .rxPopValid(rxPopValid),
		.rxPopData(rxPopData), .rxPopReady(rxPopReady));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input cifr_word_t e, input cifr_word_t g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] dat);
		int n;
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 300);
		if (n >= 300) miscompares++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	function automatic cifr_word_t fl();
		return {10'h0, liveFlags, st};
	endfunction
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Card side stall pattern and transmit word monitor
	always @(posedge sys_clk) begin
		go <= 1'($random(seed));
		if (txPushValid === 1'b1 && txPushReady === 1'b1)
			chk("tx", txq.pop_front(), txPushData);
	end
	// Watchdog, far beyond the expected run
	initial begin
		#2000000;
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 0;
		// Gate is read and set first; every other register only after it
		apb(0, `CIFR_CLKGATE_OFS, 0);
		chk("reset", 0, rdat);
		apb(1, `CIFR_CLKGATE_OFS, 1);
		@(negedge sys_clk);
		chk("clken", 1, cardIfClkEn);
		foreach (radr[i]) begin
			apb(0, radr[i], 0);
			chk("reset", 0, rdat);
		end
		chk("irq0", 0, 32'(irq0));
		chk("irq1", 0, 32'(irq1));
		chk("txvalid", 0, 32'(txPushValid));
		$display("test reset done");
		// Sticky set, clear pattern, live bits, masks and both lines
		repeat (8) begin
			v = 11'($random(seed));
			liveFlags <= 11'($random(seed));
			@(posedge sys_clk) stickyEvt <= v;
			@(posedge sys_clk) stickyEvt <= 0;
			st = st | v;
			d = {21'h0, 11'($random(seed))};
			apb(1, `CIFR_CLEAR_OFS, d);
			st = st & ~d[10:0];
			apb(0, `CIFR_FLAGS_OFS, 0);
			chk("flags", fl(), rdat);
			chk("irq0", 32'(|(fl() & m0)), 32'(irq0));
			chk("irq1", 32'(|(fl() & m1)), 32'(irq1));
			m0 = 22'($random(seed));
			m1 = 22'($random(seed));
			apb(1, `CIFR_MASK0_OFS, 32'(m0));
			apb(1, `CIFR_MASK1_OFS, 32'(m1));
			apb(0, `CIFR_MASK0_OFS, 0);
			chk("mask0", 32'(m0), rdat);
			apb(0, `CIFR_MASK1_OFS, 0);
			chk("mask1", 32'(m1), rdat);
		end
		// Event held across the clearing edge: the set must win
		stickyEvt <= 11'h001;
		apb(1, `CIFR_CLEAR_OFS, 32'h000007ff);
		stickyEvt <= 11'h000;
		st = 11'h001;
		apb(0, `CIFR_FLAGS_OFS, 0);
		chk("setwins", fl(), rdat);
		$display("test flags done");
		// Word counter load, rounding and count down
		foreach (lens[i]) begin
			transferLength <= 16'(lens[i]);
			@(posedge sys_clk) dataEnableSet <= 1;
			@(posedge sys_clk) dataEnableSet <= 0;
			w = (lens[i] + 3) / 4;
			apb(0, `CIFR_WORDS_OFS, 0);
			chk("words", w, rdat);
			@(posedge sys_clk) wordMoved <= 1;
			repeat (3) @(posedge sys_clk);
			wordMoved <= 0;
			apb(0, `CIFR_WORDS_OFS, 0);
			chk("words", w > 3 ? w - 3 : 0, rdat);
		end
		$display("test counter done");
		// Every window address pushes in turn, then every one pops in turn
		for (int i = 0; i < `CIFR_WIN_WORDS; i++) begin
			d = $random(seed);
			txq.push_back(d);
			apb(1, `CIFR_WIN_LO_OFS + 32'(4 * i), d);
		end
		for (int i = 0; i < `CIFR_WIN_WORDS; i++) begin
			apb(0, `CIFR_WIN_LO_OFS + 32'(4 * i), 0);
			chk("rx", 32'h5a000000 + 32'(i), rdat);
		end
		repeat (20) @(posedge sys_clk);
		chk("txleft", 0, txq.size());
		$display("test window done");
		apb(0, 32'h80100044, 0);
		chk("err", 1, 32'(rerr));
		apb(1, `CIFR_CLKGATE_OFS, 0);
		@(negedge sys_clk);
		chk("clken", 0, cardIfClkEn);
		$display("test gate done");
		complete_run();
	end
endmodule
